// ==== src/psweh_err_handler.sv ====
/*
 * Write data error handler of the PCI/PCI-X side of the bridge.
 * Bus-facing capture and the PERR#/SERR# pins run on clk_pci_i; status, logging,
 * forwarding decisions and interrupt requests run on clk_sys_i.
 * Assumes configuration inputs are static while an error is in flight and that
 * the PCI clock runs freely while rst_n_i is low.
 */
`timescale 1ns/1ns
module psweh_err_handler
    import psweh_pkg::*;
(
    // System clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // PCI bus clock
    input wire logic clk_pci_i,
    // Error report from the bus target (clk_pci_i)
    input wire logic err_valid_i,
    input wire psweh_pkg::psweh_wr_kind_t err_kind_i,
    input wire logic [psweh_pkg::HDR_CMD_W-1:0] err_cmd_i,
    input wire logic [psweh_pkg::HDR_ATTR_W-1:0] err_attr_i,
    input wire logic [psweh_pkg::HDR_ADDR_W-1:0] err_addr_i,
    output logic err_ready_o,
    output logic pcix_np_done_o,
    // Open-drain bus pins (clk_pci_i)
    output logic perr_o,
    output logic perr_oe_o,
    output logic serr_o,
    output logic serr_oe_o,
    // Configuration (clk_sys_i)
    input wire logic perr_resp_en_i,
    input wire logic serr_en_i,
    input wire logic int_disable_i,
    input wire logic sec_perr_resp_en_i,
    input wire logic ude_mask_i,
    input wire logic ude_sev_fatal_i,
    input wire logic devctl_fatal_en_i,
    input wire logic devctl_nonfatal_en_i,
    input wire logic rootctl_se_fatal_i,
    input wire logic rootctl_se_nonfatal_i,
    input wire logic rooterr_fatal_en_i,
    input wire logic rooterr_nonfatal_en_i,
    input wire logic msi_en_i,
    // Status clears, one-cycle pulses (clk_sys_i)
    input wire logic clr_det_par_i,
    input wire logic clr_sec_mdpe_i,
    input wire logic clr_ude_i,
    input wire logic clr_fatal_i,
    input wire logic clr_nonfatal_i,
    input wire logic clr_sig_se_i,
    // Status and log (clk_sys_i)
    output logic det_par_o,
    output logic sec_mdpe_o,
    output logic ude_sts_o,
    output logic fatal_det_o,
    output logic nonfatal_det_o,
    output logic sig_se_o,
    output logic first_ptr_active_o,
    output logic [psweh_pkg::PTR_W-1:0] secondary_error_pointer_reg,
    output logic [psweh_pkg::HDR_CMD_W-1:0] log_cmd_o,
    output logic [psweh_pkg::HDR_ATTR_W-1:0] log_attr_o,
    output logic [psweh_pkg::HDR_ADDR_W-1:0] log_addr_o,
    // Upstream forwarding and interrupt requests (clk_sys_i)
    output logic fwd_valid_o,
    output logic fwd_poison_o,
    output logic fwd_drop_o,
    output logic [psweh_pkg::HDR_CMD_W-1:0] fwd_cmd_o,
    output logic [psweh_pkg::HDR_ADDR_W-1:0] fwd_addr_o,
    output logic msi_o,
    output logic intx_o
);
    import psweh_pkg::*;

    // ==========================================================
    // PCI domain: reset and configuration synchronisers
    logic rst_pci_meta_reg;
    logic rst_pci_n_reg;
    logic perr_en_meta_reg;
    logic perr_en_pci_reg;
    logic ack_meta_reg;
    logic ack_sync_reg;
    logic serr_meta_reg;
    logic serr_sync_reg;
    logic serr_seen_reg;
    // Toggles launched in the system domain, read here only through two flops
    logic ack_tgl_reg;
    logic serr_tgl_reg;

    always_ff @(posedge clk_pci_i) begin
        rst_pci_meta_reg <= rst_n_i;
        rst_pci_n_reg <= rst_pci_meta_reg;
    end

    always_ff @(posedge clk_pci_i) begin
        if (!rst_pci_n_reg) begin
            perr_en_meta_reg <= 1'b0;
            perr_en_pci_reg <= 1'b0;
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
            serr_meta_reg <= 1'b0;
            serr_sync_reg <= 1'b0;
        end else begin
            perr_en_meta_reg <= perr_resp_en_i;
            perr_en_pci_reg <= perr_en_meta_reg;
            ack_meta_reg <= ack_tgl_reg;
            ack_sync_reg <= ack_meta_reg;
            serr_meta_reg <= serr_tgl_reg;
            serr_sync_reg <= serr_meta_reg;
        end
    end

    // ==========================================================
    // PCI domain: capture and hold one error report
    psweh_lnk_st_t lnk_st_reg;
    psweh_lnk_st_t lnk_st_next;
    logic req_tgl_reg;
    logic accept;
    psweh_wr_kind_t hold_kind_reg;
    logic [HDR_CMD_W-1:0] hold_cmd_reg;
    logic [HDR_ATTR_W-1:0] hold_attr_reg;
    logic [HDR_ADDR_W-1:0] hold_addr_reg;

    // Only one report is in flight; the header stays frozen until the system side acks
    assign accept = err_valid_i && err_ready_o;

    always_comb begin
        lnk_st_next = lnk_st_reg;
        unique case (lnk_st_reg)
            LNK_IDLE: begin
                if (accept) begin
                    lnk_st_next = LNK_BUSY;
                end
            end
            LNK_BUSY: begin
                if (ack_sync_reg == req_tgl_reg) begin
                    lnk_st_next = LNK_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_pci_i) begin
        if (!rst_pci_n_reg) begin
            lnk_st_reg <= LNK_IDLE;
            err_ready_o <= 1'b0;
            req_tgl_reg <= 1'b0;
        end else begin
            lnk_st_reg <= lnk_st_next;
            err_ready_o <= (lnk_st_next == LNK_IDLE);
            if (accept) begin
                req_tgl_reg <= ~req_tgl_reg;
            end
        end
    end

    always_ff @(posedge clk_pci_i) begin
        if (!rst_pci_n_reg) begin
            hold_kind_reg <= WR_POSTED;
            hold_cmd_reg <= HDR_CMD_RST;
            hold_attr_reg <= HDR_ATTR_RST;
            hold_addr_reg <= HDR_ADDR_RST;
        end else if (accept) begin
            hold_kind_reg <= err_kind_i;
            hold_cmd_reg <= err_cmd_i;
            hold_attr_reg <= err_attr_i;
            hold_addr_reg <= err_addr_i;
        end
    end

    // ==========================================================
    // PCI domain: PERR#, SERR# and PCI-X transfer completion
    always_ff @(posedge clk_pci_i) begin
        if (!rst_pci_n_reg) begin
            perr_oe_o <= 1'b0;
            perr_o <= 1'b1;
            pcix_np_done_o <= 1'b0;
        end else begin
            perr_oe_o <= accept && perr_en_pci_reg;
            perr_o <= 1'b0;
            pcix_np_done_o <= accept && (err_kind_i == WR_NP_PCIX);
        end
    end

    always_ff @(posedge clk_pci_i) begin
        if (!rst_pci_n_reg) begin
            serr_seen_reg <= 1'b0;
            serr_oe_o <= 1'b0;
            serr_o <= 1'b1;
        end else begin
            serr_seen_reg <= serr_sync_reg;
            serr_oe_o <= serr_sync_reg != serr_seen_reg;
            serr_o <= 1'b0;
        end
    end

    // ==========================================================
    // System domain: request synchroniser and decisions
    logic req_meta_reg;
    logic req_sync_reg;
    logic req_seen_reg;
    logic evt;
    logic poison_fwd;
    logic discard;
    logic serr_cond;
    logic int_cond;
    logic do_log;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            req_seen_reg <= 1'b0;
            ack_tgl_reg <= 1'b0;
        end else begin
            req_meta_reg <= req_tgl_reg;
            req_sync_reg <= req_meta_reg;
            req_seen_reg <= req_sync_reg;
            ack_tgl_reg <= req_seen_reg;
        end
    end

    assign evt = req_sync_reg != req_seen_reg;
    // Config is sampled here, not in the PCI domain, so a mid-flight change may split PERR# and drop
    assign poison_fwd = (hold_kind_reg == WR_POSTED) || ((hold_kind_reg == WR_NP_CONV) && !perr_resp_en_i);
    assign discard = !poison_fwd;
    assign serr_cond = !ude_mask_i && (serr_en_i ||
        (psweh_sev_sel(devctl_fatal_en_i, devctl_nonfatal_en_i, ude_sev_fatal_i) &&
         psweh_sev_sel(rootctl_se_fatal_i, rootctl_se_nonfatal_i, ude_sev_fatal_i)));
    assign int_cond = !int_disable_i && !ude_mask_i &&
        psweh_sev_sel(rooterr_fatal_en_i, rooterr_nonfatal_en_i, ude_sev_fatal_i) &&
        (serr_en_i || psweh_sev_sel(devctl_fatal_en_i, devctl_nonfatal_en_i, ude_sev_fatal_i));
    assign do_log = evt && !ude_mask_i && !first_ptr_active_o;

    // ==========================================================
    // System domain: forwarding upstream
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            fwd_valid_o <= 1'b0;
            fwd_poison_o <= 1'b0;
            fwd_drop_o <= 1'b0;
            fwd_cmd_o <= HDR_CMD_RST;
            fwd_addr_o <= HDR_ADDR_RST;
        end else begin
            fwd_valid_o <= evt && poison_fwd;
            fwd_poison_o <= evt && poison_fwd;
            fwd_drop_o <= evt && discard;
            if (evt) begin
                fwd_cmd_o <= hold_cmd_reg;
                fwd_addr_o <= hold_addr_reg;
            end
        end
    end

    // ==========================================================
    // System domain: sticky status, a new event wins over a clear
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            det_par_o <= STS_RST;
            sec_mdpe_o <= STS_RST;
            ude_sts_o <= STS_RST;
            fatal_det_o <= STS_RST;
            nonfatal_det_o <= STS_RST;
            sig_se_o <= STS_RST;
        end else begin
            det_par_o <= evt || (det_par_o && !clr_det_par_i);
            sec_mdpe_o <= (evt && poison_fwd && sec_perr_resp_en_i) || (sec_mdpe_o && !clr_sec_mdpe_i);
            ude_sts_o <= evt || (ude_sts_o && !clr_ude_i);
            fatal_det_o <= (evt && ude_sev_fatal_i) || (fatal_det_o && !clr_fatal_i);
            nonfatal_det_o <= (evt && !ude_sev_fatal_i) || (nonfatal_det_o && !clr_nonfatal_i);
            sig_se_o <= (evt && !ude_mask_i && serr_en_i) || (sig_se_o && !clr_sig_se_i);
        end
    end

    // ==========================================================
    // System domain: header log and first error pointer
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            first_ptr_active_o <= STS_RST;
            secondary_error_pointer_reg <= SEC_PTR_RST;
            log_cmd_o <= HDR_CMD_RST;
            log_attr_o <= HDR_ATTR_RST;
            log_addr_o <= HDR_ADDR_RST;
        end else begin
            first_ptr_active_o <= do_log || (first_ptr_active_o && !clr_ude_i);
            if (do_log) begin
                secondary_error_pointer_reg <= SEC_PTR_UDE;
                log_cmd_o <= hold_cmd_reg;
                log_attr_o <= hold_attr_reg;
                log_addr_o <= hold_addr_reg;
            end
        end
    end

    // ==========================================================
    // System domain: SERR# request and interrupt
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            serr_tgl_reg <= 1'b0;
            msi_o <= 1'b0;
            intx_o <= 1'b0;
        end else begin
            // SERR# request crosses as a toggle
            if (evt && serr_cond) begin
                serr_tgl_reg <= ~serr_tgl_reg;
            end
            msi_o <= evt && int_cond && msi_en_i;
            // INTA# is a level; it drops when software clears the error status
            intx_o <= (evt && int_cond && !msi_en_i) || (intx_o && !clr_ude_i);
        end
    end

    // ==========================================================
    // Checks
    sequence s_evt_posted;
        evt && (hold_kind_reg == WR_POSTED);
    endsequence

    sequence s_evt_conv;
        evt && (hold_kind_reg == WR_NP_CONV);
    endsequence

    property p_perr_gate;
        @(posedge clk_pci_i) disable iff (!rst_pci_n_reg)
        accept |=> (perr_oe_o == $past(perr_en_pci_reg)) && !perr_o;
    endproperty
    a_perr_gate: assert property (p_perr_gate) else $error("PERR# not gated by response enable");

    property p_det_par;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        evt |=> det_par_o && ude_sts_o;
    endproperty
    a_det_par: assert property (p_det_par) else $error("parity status not set");

    property p_posted_fwd;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s_evt_posted |=> fwd_valid_o && fwd_poison_o && !fwd_drop_o;
    endproperty
    a_posted_fwd: assert property (p_posted_fwd) else $error("posted write not forwarded poisoned");

    property p_sec_mdpe;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (evt && poison_fwd && sec_perr_resp_en_i) |=> sec_mdpe_o;
    endproperty
    a_sec_mdpe: assert property (p_sec_mdpe) else $error("master data parity error not set");

    property p_log;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        do_log |=> first_ptr_active_o && (secondary_error_pointer_reg == SEC_PTR_UDE) &&
            (log_addr_o == $past(hold_addr_reg));
    endproperty
    a_log: assert property (p_log) else $error("header not logged");

    property p_conv;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s_evt_conv |=> (fwd_drop_o == $past(perr_resp_en_i)) && (fwd_valid_o == !$past(perr_resp_en_i));
    endproperty
    a_conv: assert property (p_conv) else $error("conventional non-posted handling wrong");

    property p_pcix;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (evt && (hold_kind_reg == WR_NP_PCIX)) |=> fwd_drop_o && !fwd_valid_o;
    endproperty
    a_pcix: assert property (p_pcix) else $error("PCI-X non-posted write not discarded");

    property p_serr;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        evt |=> (serr_tgl_reg != $past(serr_tgl_reg)) == $past(serr_cond);
    endproperty
    a_serr: assert property (p_serr) else $error("SERR# request wrong");

    property p_msi;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (evt && int_cond) |=> (msi_o == $past(msi_en_i)) && (intx_o || $past(msi_en_i));
    endproperty
    a_msi: assert property (p_msi) else $error("interrupt request wrong");

    property p_sev;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        evt |=> ($past(ude_sev_fatal_i) ? fatal_det_o : nonfatal_det_o);
    endproperty
    a_sev: assert property (p_sev) else $error("severity status not set");

    property p_sig_se;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (evt && !ude_mask_i && serr_en_i) |=> sig_se_o;
    endproperty
    a_sig_se: assert property (p_sig_se) else $error("signaled system error not set");

    property p_block;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (first_ptr_active_o && !clr_ude_i) |=> first_ptr_active_o && $stable(log_addr_o) && $stable(log_cmd_o);
    endproperty
    a_block: assert property (p_block) else $error("log overwritten while pointer active");

endmodule

// ==== src/psweh_pkg.sv ====
/*
 * Shared constants, types and helpers for the write data error handler.
 * Assumes the bridge configuration bits are quasi-static while errors are being handled.
 */
package psweh_pkg;

    // ==========================================================
    // Header log field widths
    localparam int HDR_CMD_W = 4;
    localparam int HDR_ATTR_W = 32;
    localparam int HDR_ADDR_W = 32;

    // ==========================================================
    // Error pointer encoding and reset values
    localparam int PTR_W = 5;
    localparam logic [PTR_W-1:0] SEC_PTR_UDE = 5'h08;
    localparam logic [PTR_W-1:0] SEC_PTR_RST = 5'h00;
    localparam logic STS_RST = 1'b0;
    localparam logic [HDR_CMD_W-1:0] HDR_CMD_RST = 4'h0;
    localparam logic [HDR_ATTR_W-1:0] HDR_ATTR_RST = 32'h0;
    localparam logic [HDR_ADDR_W-1:0] HDR_ADDR_RST = 32'h0;

    // ==========================================================
    // Write kinds and link-side handshake states
    typedef enum logic [1:0] {
        WR_POSTED  = 2'h0,
        WR_NP_CONV = 2'h1,
        WR_NP_PCIX = 2'h2
    } psweh_wr_kind_t;

    typedef enum logic {
        LNK_IDLE = 1'b0,
        LNK_BUSY = 1'b1
    } psweh_lnk_st_t;

    // ==========================================================
    // Picks the fatal or non-fatal enable by the configured severity
    function automatic logic psweh_sev_sel(input logic fatal_en, input logic nonfatal_en, input logic sev_fatal);
        psweh_sev_sel = sev_fatal ? fatal_en : nonfatal_en;
    endfunction

endpackage

// ==== verification/pci_side_write_data_error_handler_tb.sv ====
/*
 * Self-checking bench for the write data error handler, random configurations.
 * Assumes the design package and the bus-side model are compiled before it.
 */
`timescale 1ns/1ns
module pci_side_write_data_error_handler_tb;
    import psweh_pkg::*;

    typedef struct {
        logic drop;
        logic [HDR_CMD_W-1:0] cmd;
        logic [HDR_ADDR_W-1:0] addr;
        logic msi, intx, sec, sev, sig, ptr;
        logic [HDR_CMD_W-1:0] lcmd;
        logic [HDR_ATTR_W-1:0] lattr;
        logic [HDR_ADDR_W-1:0] laddr;
    } psweh_note_t;

    logic clk_sys_i, clk_pci_i, rst_n_i, err_valid_i;
    psweh_wr_kind_t err_kind_i;
    logic [HDR_CMD_W-1:0] err_cmd_i, log_cmd_o, fwd_cmd_o;
    logic [HDR_ATTR_W-1:0] err_attr_i, log_attr_o;
    logic [HDR_ADDR_W-1:0] err_addr_i, log_addr_o, fwd_addr_o;
    logic [PTR_W-1:0] sep;
    logic err_ready_o, pcix_np_done_o, perr_o, perr_oe_o, serr_o, serr_oe_o;
    logic det_par_o, sec_mdpe_o, ude_sts_o, fatal_det_o, nonfatal_det_o, sig_se_o;
    logic first_ptr_active_o, fwd_valid_o, fwd_poison_o, fwd_drop_o, msi_o, intx_o;
    // Config: 0 perr resp, 1 serr en, 2 int dis, 3 sec perr resp, 4 mask, 5 fatal,
    // 6/7 devctl f/nf, 8/9 rootctl f/nf, 10/11 rooterr f/nf, 12 msi en
    logic [12:0] cfg;
    // Clears: 0 det par, 1 sec mdpe, 2 ude, 3 fatal, 4 nonfatal, 5 sig se
    logic [5:0] clr;
    psweh_note_t q[$];
    psweh_note_t e;
    int n_fail = 0, check_count = 0, n_res = 0, n_perr = 0, n_serr = 0, n_done = 0;
    int cyc = 0, seed = 20207;

    psweh_err_handler u_psweh_err_handler (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_pci_i(clk_pci_i),
        .err_valid_i(err_valid_i), .err_kind_i(err_kind_i), .err_cmd_i(err_cmd_i),
        .err_attr_i(err_attr_i), .err_addr_i(err_addr_i), .err_ready_o(err_ready_o),
        .pcix_np_done_o(pcix_np_done_o), .perr_o(perr_o), .perr_oe_o(perr_oe_o),
        .serr_o(serr_o), .serr_oe_o(serr_oe_o),
        .perr_resp_en_i(cfg[0]), .serr_en_i(cfg[1]), .int_disable_i(cfg[2]),
        .sec_perr_resp_en_i(cfg[3]), .ude_mask_i(cfg[4]), .ude_sev_fatal_i(cfg[5]),
        .devctl_fatal_en_i(cfg[6]), .devctl_nonfatal_en_i(cfg[7]), .rootctl_se_fatal_i(cfg[8]),
        .rootctl_se_nonfatal_i(cfg[9]), .rooterr_fatal_en_i(cfg[10]),
        .rooterr_nonfatal_en_i(cfg[11]), .msi_en_i(cfg[12]),
        .clr_det_par_i(clr[0]), .clr_sec_mdpe_i(clr[1]), .clr_ude_i(clr[2]),
        .clr_fatal_i(clr[3]), .clr_nonfatal_i(clr[4]), .clr_sig_se_i(clr[5]),
        .det_par_o(det_par_o), .sec_mdpe_o(sec_mdpe_o), .ude_sts_o(ude_sts_o),
        .fatal_det_o(fatal_det_o), .nonfatal_det_o(nonfatal_det_o), .sig_se_o(sig_se_o),
        .first_ptr_active_o(first_ptr_active_o), .secondary_error_pointer_reg(sep),
        .log_cmd_o(log_cmd_o), .log_attr_o(log_attr_o), .log_addr_o(log_addr_o),
        .fwd_valid_o(fwd_valid_o), .fwd_poison_o(fwd_poison_o), .fwd_drop_o(fwd_drop_o),
        .fwd_cmd_o(fwd_cmd_o), .fwd_addr_o(fwd_addr_o), .msi_o(msi_o), .intx_o(intx_o)
    );

    psweh_pci_master u_psweh_pci_master (
        .clk_pci_i(clk_pci_i), .err_ready_i(err_ready_o), .err_valid_o(err_valid_i),
        .err_kind_o(err_kind_i), .err_cmd_o(err_cmd_i), .err_attr_o(err_attr_i),
        .err_addr_o(err_addr_i)
    );

    // ==========================================================
    // Clocks, unrelated in phase
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        clk_pci_i = 1'b0;
        #37;
        forever #80 clk_pci_i = ~clk_pci_i;
    end

    task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // ==========================================================
    // Pin pulses; PERR#/SERR# count only when driven low, the PCI-X done pulse when high
    always @(negedge clk_pci_i) begin
        if (perr_oe_o === 1'b1 && perr_o === 1'b0) n_perr++;
        if (serr_oe_o === 1'b1 && serr_o === 1'b0) n_serr++;
        if (pcix_np_done_o === 1'b1) n_done++;
    end

    // ==========================================================
    // Result watcher
    always @(negedge clk_sys_i) begin
        if (rst_n_i === 1'b1 && (fwd_valid_o === 1'b1 || fwd_drop_o === 1'b1)) begin
            if (q.size() == 0) begin
                check("unexpected result", 1'b1, 1'b0);
            end else begin
                e = q.pop_front();
                check("drop", fwd_drop_o, e.drop);
                check("poison", {fwd_valid_o, fwd_poison_o}, {2{!e.drop}});
                check("fwd header", {fwd_cmd_o, fwd_addr_o}, {e.cmd, e.addr});
                check("detected", {det_par_o, ude_sts_o}, 2'h3);
                check("sec mdpe", sec_mdpe_o, e.sec);
                check("severity", {fatal_det_o, nonfatal_det_o}, {e.sev, !e.sev});
                check("sig se", sig_se_o, e.sig);
                check("msi intx", {msi_o, intx_o}, {e.msi, e.intx});
                check("log", {first_ptr_active_o, log_cmd_o, log_attr_o, log_addr_o},
                      {e.ptr, e.lcmd, e.lattr, e.laddr});
                if (e.ptr) check("pointer", sep, SEC_PTR_UDE);
                n_res++;
            end
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        psweh_note_t n;
        psweh_wr_kind_t k;
        logic [31:0] r, at, ad;
        logic [HDR_CMD_W-1:0] c, lc;
        logic [HDR_ATTR_W-1:0] lat;
        logic [HDR_ADDR_W-1:0] lad;
        logic dc, rc, re, intc, ptr_on, intx_m;
        cfg = 13'h0000;
        clr = 6'h00;
        rst_n_i = 1'b0;
        lc = HDR_CMD_RST;
        lat = HDR_ATTR_RST;
        lad = HDR_ADDR_RST;
        ptr_on = 1'b0;
        intx_m = 1'b0;
        // Held for PCI edges too, since the PCI reset is synchronised from this one
        repeat (3) @(posedge clk_sys_i);
        repeat (3) @(posedge clk_pci_i);
        #2;
        check("in reset", {err_ready_o, perr_o, serr_o, det_par_o, ude_sts_o, first_ptr_active_o, sep, intx_o},
              {3'h3, 3'h0, SEC_PTR_RST, 1'h0});
        @(posedge clk_sys_i);
        #2;
        rst_n_i = 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk_sys_i);
            #2;
            cfg = 13'($random(seed));
            clr = 6'h3B;
            clr[2] = 1'($random(seed));
            if (clr[2]) begin
                ptr_on = 1'b0;
                intx_m = 1'b0;
            end
            @(posedge clk_sys_i);
            #2;
            clr = 6'h00;
            @(posedge clk_sys_i);
            #2;
            check("cleared", {det_par_o, sec_mdpe_o, fatal_det_o, nonfatal_det_o, sig_se_o}, 5'h00);
            // Let the new parity response enable settle through the PCI-side synchroniser
            repeat (3) @(posedge clk_pci_i);
            r = $random(seed);
            at = $random(seed);
            ad = $random(seed);
            c = r[11:8];
            k = psweh_wr_kind_t'(2'(r[7:0] % 8'h03));
            dc = cfg[5] ? cfg[6] : cfg[7];
            rc = cfg[5] ? cfg[8] : cfg[9];
            re = cfg[5] ? cfg[10] : cfg[11];
            intc = !cfg[2] && !cfg[4] && re && (cfg[1] || dc);
            intx_m = intx_m | (intc && !cfg[12]);
            if (!cfg[4] && !ptr_on) begin
                lc = c;
                lat = at;
                lad = ad;
                ptr_on = 1'b1;
            end
            n = '{drop: (k == WR_NP_PCIX) || (k == WR_NP_CONV && cfg[0]), cmd: c, addr: ad,
                  msi: intc && cfg[12], intx: intx_m, sec: 1'b0, sev: cfg[5], sig: !cfg[4] && cfg[1],
                  ptr: ptr_on, lcmd: lc, lattr: lat, laddr: lad};
            n.sec = !n.drop && cfg[3];
            q.push_back(n);
            n_perr = 0;
            n_serr = 0;
            n_done = 0;
            u_psweh_pci_master.send(k, c, at, ad);
            for (int w = 0; w < 300 && n_res <= i; w++) @(posedge clk_sys_i);
            repeat (12) @(posedge clk_pci_i);
            check("result count", n_res, i + 1);
            check("perr pulses", n_perr, cfg[0]);
            check("serr pulses", n_serr, !cfg[4] && (cfg[1] || (dc && rc)));
            check("np done pulses", n_done, k == WR_NP_PCIX);
        end
        tally_and_finish();
    end
endmodule

// ==== verification/psweh_pci_master.sv ====
/*
 * Behavioural model of the bus side that reports write data errors to the handler.
 * Assumes a free-running PCI clock and the valid/ready contract of the handler.
 */
`timescale 1ns/1ns
module psweh_pci_master
    import psweh_pkg::*;
(
    // Link clock
    input wire logic clk_pci_i,
    // Error report handshake
    input wire logic err_ready_i,
    output logic err_valid_o,
    output psweh_pkg::psweh_wr_kind_t err_kind_o,
    output logic [psweh_pkg::HDR_CMD_W-1:0] err_cmd_o,
    output logic [psweh_pkg::HDR_ATTR_W-1:0] err_attr_o,
    output logic [psweh_pkg::HDR_ADDR_W-1:0] err_addr_o
);
    initial begin
        err_valid_o = 1'b0;
        err_kind_o = WR_POSTED;
        err_cmd_o = HDR_CMD_RST;
        err_attr_o = HDR_ATTR_RST;
        err_addr_o = HDR_ADDR_RST;
    end

    // ==========================================================
    // One report, raised once ready or after 100 edges without ready, and held for one edge
    task automatic send(input psweh_wr_kind_t k, input logic [HDR_CMD_W-1:0] c,
                        input logic [HDR_ATTR_W-1:0] at, input logic [HDR_ADDR_W-1:0] ad);
        int n;
        n = 0;
        do begin
            @(posedge clk_pci_i);
            #2;
            n++;
        end while (err_ready_i !== 1'b1 && n < 100);
        err_valid_o = 1'b1;
        err_kind_o = k;
        err_cmd_o = c;
        err_attr_o = at;
        err_addr_o = ad;
        @(posedge clk_pci_i);
        #2;
        // Released lines show the inverse so that stale data cannot pass for good
        err_valid_o = 1'b0;
        err_kind_o = psweh_wr_kind_t'(~k);
        err_cmd_o = ~c;
        err_attr_o = ~at;
        err_addr_o = ~ad;
    endtask
endmodule
